// File: rtl/presettable_ripple_counter.sv
// Contract
// - The decade build has its own divide-by-two stage and a divide-by-five section.
// - The binary build has a divide-by-two stage and a divide-by-eight section, 16 states chained.
// - A low clear input drives every output low whatever the clocks, load or preset.
// - A low load input copies the preset inputs into the stages with no clock edge and stops counting.
// - While load is low the block is transparent, preset changes reach the outputs.
// - After load goes high with no clock edges the loaded value is held.
// - In counting each stage changes only on a falling edge of the clock feeding it.
// - Stage outputs change one after another, except in the decade build, where the top stage switches in the same cycle as the second output.
// - The first clock feeds only the lowest stage, the second clock feeds the upper section.
// - Binary build chained from the lowest output counts modulo 16, lowest output the LSB.
// - Decade build chained the same way counts 0 to 9 in 8-4-2-1 code and wraps to 0.
// - Decade build clocked on the upper input, top output feeding the first clock, is bi-quinary.
`timescale 1ns/1ps
`include "ripple_counter_defs.svh"
module presettable_ripple_counter #(
  parameter bit IS_DECADE = 1'b1
) (
  input  wire logic                 sys_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 first_stage_clock_n,
  input  wire logic                 upper_section_clock_n,
  input  wire logic                 clear_all_n,
  input  wire logic                 load_enable_n,
  input  wire ripple_pkg::nibble_type preset_in,
  output ripple_pkg::nibble_type      count_out,
  output logic                      ripple_busy
);
  import ripple_pkg::*;

  logic [`SYNC_WIDTH-1:0] pins_raw;
  logic [`SYNC_WIDTH-1:0] pins_s;
  nibble_type             preset_s;
  logic                   clear_n_s;
  logic                   load_n_s;
  logic                   clk0_s;
  logic                   clk1_s;
  mode_type               mode;
  logic                   fall0;
  logic                   fall1;
  logic                   prev0_q;
  logic                   prev0_d;
  logic                   prev1_q;
  logic                   prev1_d;
  logic                   stage0_q;
  logic                   stage0_d;
  logic [2:0]             upper_cnt;
  logic                   upper_busy;

  assign pins_raw = {upper_section_clock_n, first_stage_clock_n,
                     load_enable_n, clear_all_n, preset_in};

  // Every pin is asynchronous to sys_clk
  pin_sync #(
    .WIDTH       (`SYNC_WIDTH),
    .RESET_VALUE (`SYNC_RESET_VALUE)
  ) u_sync (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .din     (pins_raw),
    .dout    (pins_s)
  );

  assign preset_s  = pins_s[`SYNC_PRESET_LSB +: 4];
  assign clear_n_s = pins_s[`SYNC_CLEAR_BIT];
  assign load_n_s  = pins_s[`SYNC_LOAD_BIT];
  assign clk0_s    = pins_s[`SYNC_CLK0_BIT];
  assign clk1_s    = pins_s[`SYNC_CLK1_BIT];

  always_comb begin
    if (!clear_n_s) begin
      mode = MODE_CLEAR;
    end else if (!load_n_s) begin
      mode = MODE_LOAD;
    end else begin
      mode = MODE_COUNT;
    end
  end

  // Falling edges only; a level change under clear or load is dropped
  assign fall0 = prev0_q & ~clk0_s;
  assign fall1 = prev1_q & ~clk1_s;

  always_comb begin
    prev0_d  = clk0_s;
    prev1_d  = clk1_s;
    stage0_d = stage0_q;
    case (mode)
      MODE_CLEAR: stage0_d = 1'b0;
      MODE_LOAD:  stage0_d = preset_s[0];
      MODE_COUNT: begin
        if (fall0) begin
          stage0_d = ~stage0_q;
        end
      end
      default:    stage0_d = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev0_q  <= `PIN_IDLE_VALUE;
      prev1_q  <= `PIN_IDLE_VALUE;
      stage0_q <= 1'b0;
    end else begin
      prev0_q  <= prev0_d;
      prev1_q  <= prev1_d;
      stage0_q <= stage0_d;
    end
  end

  upper_section #(
    .IS_DECADE (IS_DECADE)
  ) u_upper (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .clear   (mode == MODE_CLEAR),
    .load    (mode == MODE_LOAD),
    .preset  (preset_s[3:1]),
    .fall    (fall1 && mode == MODE_COUNT),
    .count   (upper_cnt),
    .busy    (upper_busy)
  );

  // Chaining between sections is external, so a carry crosses the sync
  assign count_out   = {upper_cnt, stage0_q};
  assign ripple_busy = upper_busy;

  property p_clear;
    @(posedge sys_clk) disable iff (sys_rst)
      !clear_n_s |=> count_out == `CNT_RESET_VALUE;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear did not zero the outputs");

  property p_clear_wins;
    @(posedge sys_clk) disable iff (sys_rst)
      (!clear_n_s && !load_n_s) |=> count_out == `CNT_RESET_VALUE
                                    && !ripple_busy;
  endproperty
  a_clear_wins: assert property (p_clear_wins)
    else $error("load beat clear");

  property p_load;
    @(posedge sys_clk) disable iff (sys_rst)
      (clear_n_s && !load_n_s) |=> count_out == $past(preset_s);
  endproperty
  a_load: assert property (p_load)
    else $error("load did not copy the preset");

  property p_transparent;
    @(posedge sys_clk) disable iff (sys_rst)
      (clear_n_s && !load_n_s)[*2] |-> count_out == $past(preset_s);
  endproperty
  a_transparent: assert property (p_transparent)
    else $error("output did not follow preset under load");

  property p_hold;
    @(posedge sys_clk) disable iff (sys_rst)
      (mode == MODE_COUNT && !fall0 && !fall1 && !ripple_busy)
        |=> $stable(count_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("stored value changed without an edge");

  property p_stage0_edge;
    @(posedge sys_clk) disable iff (sys_rst)
      (mode == MODE_COUNT && fall0) |=> count_out[0] != $past(count_out[0]);
  endproperty
  a_stage0_edge: assert property (p_stage0_edge)
    else $error("lowest stage missed its falling edge");

  property p_upper_isolated;
    @(posedge sys_clk) disable iff (sys_rst)
      (mode == MODE_COUNT && !fall1 && !ripple_busy)
        |=> $stable(count_out[3:1]);
  endproperty
  a_upper_isolated: assert property (p_upper_isolated)
    else $error("upper section moved without its own clock");

  property p_ripple;
    @(posedge sys_clk) disable iff (sys_rst)
      (mode == MODE_COUNT && fall1 && count_out[1])
        ##1 (mode == MODE_COUNT) |-> ripple_busy;
  endproperty
  a_ripple: assert property (p_ripple)
    else $error("carry did not ripple a cycle late");

  property p_upper_step;
    @(posedge sys_clk) disable iff (sys_rst)
      (mode == MODE_COUNT && fall1 && !ripple_busy
       && count_out[3:1] == 3'h0) |=> count_out[3:1] == 3'h1;
  endproperty
  a_upper_step: assert property (p_upper_step)
    else $error("upper section failed to step from zero");

  property p_clear_idle;
    @(posedge sys_clk) disable iff (sys_rst)
      !clear_n_s |=> !ripple_busy;
  endproperty
  a_clear_idle: assert property (p_clear_idle)
    else $error("ripple still busy under clear");

  property p_load_idle;
    @(posedge sys_clk) disable iff (sys_rst)
      (clear_n_s && !load_n_s) |=> !ripple_busy;
  endproperty
  a_load_idle: assert property (p_load_idle)
    else $error("ripple still busy under load");

  property p_load_ignores_clock;
    @(posedge sys_clk) disable iff (sys_rst)
      (clear_n_s && !load_n_s && (fall0 || fall1))
        |=> count_out == $past(preset_s);
  endproperty
  a_load_ignores_clock: assert property (p_load_ignores_clock)
    else $error("clock edge counted during load");

  property p_stage0_isolated;
    @(posedge sys_clk) disable iff (sys_rst)
      (mode == MODE_COUNT && !fall0)
        |=> $stable(count_out[0]);
  endproperty
  a_stage0_isolated: assert property (p_stage0_isolated)
    else $error("lowest stage moved without its own clock");

  // Carry must land a cycle later, never with the first upper stage
  property p_ripple_order;
    @(posedge sys_clk) disable iff (sys_rst)
      (mode == MODE_COUNT && fall1 && !ripple_busy && count_out[1])
        |=> $stable(count_out[2]);
  endproperty
  a_ripple_order: assert property (p_ripple_order)
    else $error("second stage switched with the first");

  property p_carry_lands;
    @(posedge sys_clk) disable iff (sys_rst)
      (mode == MODE_COUNT && fall1 && !ripple_busy && count_out[1])
        ##1 (mode == MODE_COUNT) |=> count_out[2] != $past(count_out[2]);
  endproperty
  a_carry_lands: assert property (p_carry_lands)
    else $error("carry into the second stage was lost");

  property p_busy_bounded;
    @(posedge sys_clk) disable iff (sys_rst)
      (ripple_busy && !fall1) ##1 (ripple_busy && !fall1) |=> !ripple_busy;
  endproperty
  a_busy_bounded: assert property (p_busy_bounded)
    else $error("carry rippled longer than the stage count");

  property p_hold_after_load;
    @(posedge sys_clk) disable iff (sys_rst)
      (mode == MODE_LOAD) ##1 (mode == MODE_COUNT && !fall0 && !fall1)
        |=> count_out == $past(preset_s, 2);
  endproperty
  a_hold_after_load: assert property (p_hold_after_load)
    else $error("loaded value lost after load ended");

  if (!IS_DECADE) begin : g_binary_chk
    property p_bit1_toggle;
      @(posedge sys_clk) disable iff (sys_rst)
        (mode == MODE_COUNT && fall1 && !ripple_busy)
          |=> count_out[1] != $past(count_out[1]);
    endproperty
    a_bit1_toggle: assert property (p_bit1_toggle)
      else $error("divide-by-eight input stage missed its edge");

    property p_binary_wrap;
      @(posedge sys_clk) disable iff (sys_rst)
        (mode == MODE_COUNT && fall1 && !ripple_busy
         && count_out[3:1] == 3'h7)
          ##1 (mode == MODE_COUNT && !fall1)
          ##1 (mode == MODE_COUNT && !fall1) |=> count_out[3:1] == 3'h0;
    endproperty
    a_binary_wrap: assert property (p_binary_wrap)
      else $error("divide-by-eight did not wrap after seven");
  end

  if (IS_DECADE) begin : g_decade_chk
    property p_quinary_wrap;
      @(posedge sys_clk) disable iff (sys_rst)
        (mode == MODE_COUNT && fall1 && !ripple_busy
         && count_out[3:1] == `QUINARY_TOP) |=> count_out[3:1] == 3'h0;
    endproperty
    a_quinary_wrap: assert property (p_quinary_wrap)
      else $error("divide-by-five did not wrap after four");

    property p_decade_carry;
      @(posedge sys_clk) disable iff (sys_rst)
        (mode == MODE_COUNT && fall1 && !ripple_busy
         && count_out[3:1] == 3'h3) |=> count_out[3];
    endproperty
    a_decade_carry: assert property (p_decade_carry)
      else $error("top stage missed the carry out of three");
  end

endmodule

// File: rtl/ripple_counter_defs.svh
`ifndef RIPPLE_COUNTER_DEFS_SVH
`define RIPPLE_COUNTER_DEFS_SVH

// Level of an idle pin after reset
`define PIN_IDLE_VALUE 1'b1
// Value of every stage after reset or clear
`define CNT_RESET_VALUE 4'h0
`define UPPER_RESET_VALUE 3'h0
// Synchronizer reset image: {upper clk, first clk, load_n, clear_n, preset}
`define SYNC_RESET_VALUE 8'he0
// Bit positions inside the synchronized pin vector
`define SYNC_PRESET_LSB 0
`define SYNC_CLEAR_BIT 4
`define SYNC_LOAD_BIT 5
`define SYNC_CLK0_BIT 6
`define SYNC_CLK1_BIT 7
`define SYNC_WIDTH 8
// Highest state of the divide-by-five section
`define QUINARY_TOP 3'h4

`endif

// File: rtl/ripple_pkg.sv
package ripple_pkg;

  typedef enum logic [2:0] {
    MODE_CLEAR = 3'b001,
    MODE_LOAD  = 3'b010,
    MODE_COUNT = 3'b100
  } mode_type;

  typedef logic [3:0] nibble_type;

endpackage

// File: rtl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter int              WIDTH       = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic meta_q;
    logic sync_q;
    logic meta_d;
    logic sync_d;

    always_comb begin
      meta_d = din[i];
      sync_d = meta_q;
    end

    // First flop feeds only the second one
    always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
        meta_q <= RESET_VALUE[i];
        sync_q <= RESET_VALUE[i];
      end else begin
        meta_q <= meta_d;
        sync_q <= sync_d;
      end
    end

    assign dout[i] = sync_q;
  end

endmodule

// File: rtl/upper_section.sv
`timescale 1ns/1ps
`include "ripple_counter_defs.svh"
module upper_section #(
  parameter bit IS_DECADE = 1'b1
) (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       clear,
  input  wire logic       load,
  input  wire logic [2:0] preset,
  input  wire logic       fall,
  output logic      [2:0] count,
  output logic            busy
);

  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic       pend2_q;
  logic       pend2_d;
  logic       pend3_q;
  logic       pend3_d;

  always_comb begin
    cnt_d   = cnt_q;
    pend2_d = 1'b0;
    pend3_d = 1'b0;
    if (clear) begin
      cnt_d = `UPPER_RESET_VALUE;
    end else if (load) begin
      cnt_d = preset;
    end else begin
      // Falling stage output clocks the next stage a cycle later
      if (pend2_q) begin
        cnt_d[1] = ~cnt_q[1];
        pend3_d  = cnt_q[1] & ~IS_DECADE;
      end
      if (pend3_q) begin
        cnt_d[2] = ~cnt_q[2];
      end
      if (fall) begin
        if (IS_DECADE) begin
          // Gated divide-by-five: top stage steps straight back to zero
          cnt_d[0] = ~cnt_q[0] & ~cnt_q[2];
          cnt_d[2] = cnt_q[0] & cnt_q[1];
        end else begin
          cnt_d[0] = ~cnt_q[0];
        end
        pend2_d = cnt_q[0];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q   <= `UPPER_RESET_VALUE;
      pend2_q <= 1'b0;
      pend3_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      pend2_q <= pend2_d;
      pend3_q <= pend3_d;
    end
  end

  assign count = cnt_q;
  assign busy  = pend2_q | pend3_q;

endmodule

// File: sim/clock_source_model.sv
`timescale 1ns/1ps
module clock_source_model (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic go,
  input  wire logic to_upper,
  input  wire logic q_low,
  input  wire logic q_top,
  output logic      first_stage_clock_n,
  output logic      upper_section_clock_n
);
  logic [3:0] cnt_q;
  logic       src_n;

  // One source pulse per request, four cycles low then four high
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 4'h0;
    end else if (go && cnt_q == 4'h0) begin
      cnt_q <= 4'h8;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end

  assign src_n = !(cnt_q > 4'h4);
  // Raw stage outputs only, never a decoded value, feed a clock pin
  assign first_stage_clock_n   = to_upper ? q_top : src_n;
  assign upper_section_clock_n = to_upper ? src_n : q_low;
endmodule

// File: sim/tb_presettable_ripple_counter.sv
`timescale 1ns/1ps
module tb_presettable_ripple_counter;
  import ripple_pkg::*;
  logic       sys_clk       = 1'h0;
  logic       sys_rst       = 1'h1;
  logic       clear_all_n   = 1'h0;
  logic       load_enable_n = 1'h1;
  logic       go            = 1'h0;
  logic       to_upper      = 1'h0;
  nibble_type preset_in     = 4'h0;
  nibble_type dec_out;
  nibble_type bin_out;
  logic       dec_busy;
  logic       bin_busy;
  logic       dec_c0;
  logic       dec_c1;
  logic       bin_c0;
  logic       bin_c1;
  int         mismatches    = 0;
  int         compares      = 0;

  always #5 sys_clk = ~sys_clk;

  presettable_ripple_counter #(.IS_DECADE(1'b1)) u_dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst),
    .first_stage_clock_n(dec_c0), .upper_section_clock_n(dec_c1),
    .clear_all_n(clear_all_n), .load_enable_n(load_enable_n),
    .preset_in(preset_in), .count_out(dec_out), .ripple_busy(dec_busy));
  presettable_ripple_counter #(.IS_DECADE(1'b0)) u_bin (
    .sys_clk(sys_clk), .sys_rst(sys_rst),
    .first_stage_clock_n(bin_c0), .upper_section_clock_n(bin_c1),
    .clear_all_n(clear_all_n), .load_enable_n(load_enable_n),
    .preset_in(preset_in), .count_out(bin_out), .ripple_busy(bin_busy));
  clock_source_model p_dec (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .go(go), .to_upper(to_upper),
    .q_low(dec_out[0]), .q_top(dec_out[3]),
    .first_stage_clock_n(dec_c0), .upper_section_clock_n(dec_c1));
  clock_source_model p_bin (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .go(go), .to_upper(to_upper),
    .q_low(bin_out[0]), .q_top(bin_out[3]),
    .first_stage_clock_n(bin_c0), .upper_section_clock_n(bin_c1));

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic check(input nibble_type got, input nibble_type exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Generous settle: sync, stage ripple and chained sync all fit
  task automatic pulse;
    go = 1'h1;
    tick(1);
    go = 1'h0;
    tick(24);
  endtask

  // Chain is switched under clear so a fake edge is thrown away
  task automatic restart(input logic up);
    clear_all_n   = 1'h0;
    load_enable_n = 1'h1;
    to_upper      = up;
    tick(8);
    check(dec_out, 4'h0);
    clear_all_n = 1'h1;
    tick(4);
  endtask

  task automatic t_lsb_chain;
    restart(1'h0);
    for (int i = 1; i <= 20; i++) begin
      pulse();
      check(dec_out, nibble_type'(i % 10));
      check(bin_out, nibble_type'(i % 16));
    end
  endtask

  task automatic t_biquinary;
    restart(1'h1);
    for (int i = 1; i <= 10; i++) begin
      pulse();
      check(dec_out, nibble_type'(((i % 5) << 1) | ((i / 5) % 2)));
      check(bin_out, nibble_type'(((i % 8) << 1) | ((i / 8) % 2)));
    end
  endtask

  task automatic t_load;
    restart(1'h0);
    preset_in     = 4'h7;
    load_enable_n = 1'h0;
    tick(6);
    check(dec_out, 4'h7);
    preset_in = 4'h9;
    tick(6);
    check(bin_out, 4'h9);
    pulse();
    check(dec_out, 4'h9);
    load_enable_n = 1'h1;
    tick(8);
    check(dec_out, 4'h9);
    pulse();
    check(dec_out, 4'h0);
    check(bin_out, 4'ha);
  endtask

  task automatic t_clear;
    restart(1'h0);
    pulse();
    preset_in     = 4'h5;
    load_enable_n = 1'h0;
    clear_all_n   = 1'h0;
    tick(6);
    check(dec_out, 4'h0);
    clear_all_n = 1'h1;
    tick(6);
    check(dec_out, 4'h5);
    load_enable_n = 1'h1;
    tick(4);
    clear_all_n = 1'h0;
    pulse();
    check(bin_out, 4'h0);
    clear_all_n = 1'h1;
    tick(4);
  endtask

  // Upper 011 to 100 must pass through a visible carry step
  task automatic t_ripple;
    logic seen;
    logic seen_dec;
    seen     = 1'h0;
    seen_dec = 1'h0;
    restart(1'h1);
    preset_in     = 4'h6;
    load_enable_n = 1'h0;
    tick(8);
    load_enable_n = 1'h1;
    tick(4);
    go = 1'h1;
    tick(1);
    go = 1'h0;
    for (int i = 0; i < 24; i++) begin
      if (bin_busy === 1'h1) seen = 1'h1;
      if (dec_busy === 1'h1) seen_dec = 1'h1;
      tick(1);
    end
    check({3'h0, seen}, 4'h1);
    check({3'h0, seen_dec}, 4'h1);
    check({bin_busy, 2'h0, dec_busy}, 4'h0);
    check(bin_out, 4'h8);
    check(dec_out, 4'h8);
  endtask

  task automatic give_verdict;
    $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    tick(20);
    sys_rst = 1'h0;
    tick(4);
    check(bin_out, 4'h0);
    check(dec_out, 4'h0);
    t_lsb_chain();
    t_biquinary();
    t_load();
    t_clear();
    t_ripple();
    give_verdict();
  end
endmodule
